/* hdl/lvpc_pkg.sv */
// Package of constants for the LLC/VLAN packet classifier
package lvpc_pkg;
    // Protocol selector codes
    localparam logic [7:0]  SEL_NONE      = 8'h00;
    localparam logic [7:0]  SEL_ETHERTYPE = 8'h01;
    localparam logic [7:0]  SEL_DSAP      = 8'h02;
    localparam logic [7:0]  SEL_MGMT      = 8'h03;
    localparam logic [7:0]  SEL_DATA_ALL  = 8'h04;
    // Frame constants
    localparam logic [7:0]  DSAP_SNAP     = 8'hAA;
    localparam logic [15:0] ETYPE_VLAN    = 16'h8100;
    localparam logic [6:0]  FC_MGMT_HI    = 7'h61;     // 1100001x
    localparam logic [15:0] PORT_LOW_DEF  = 16'h0000;
    localparam logic [15:0] PORT_HIGH_DEF = 16'hFFFF;  // 65 535
    // Never-classified management types
    localparam logic [7:0]  MT_RNG_REQ    = 8'h04;
    localparam logic [7:0]  MT_REG_REQ    = 8'h06;
    localparam logic [7:0]  MT_REG_RSP    = 8'h07;
    localparam logic [7:0]  MT_REG_ACK    = 8'h0E;
    // TLV type codes and lengths
    localparam logic [7:0]  TLV_LLC       = 8'h0A;
    localparam logic [7:0]  TLV_LLC_DMAC  = 8'h01;
    localparam logic [7:0]  TLV_LLC_SMAC  = 8'h02;
    localparam logic [7:0]  TLV_LLC_PROT  = 8'h03;
    localparam logic [7:0]  TLV_VLAN      = 8'h0B;
    localparam logic [7:0]  TLV_VLAN_PRI  = 8'h01;
    localparam logic [7:0]  TLV_VLAN_ID   = 8'h02;
    localparam logic [7:0]  TLV_VENDOR    = 8'h2B;
    localparam logic [7:0]  TLV_VENDOR_ID = 8'h08;
    localparam logic [7:0]  TLV_SF_UP     = 8'h18;
    localparam logic [7:0]  TLV_SF_DOWN   = 8'h19;
    localparam logic [7:0]  DMAC_LEN      = 8'h0C;
    localparam logic [7:0]  SMAC_LEN      = 8'h06;
    localparam logic [7:0]  PROT_LEN      = 8'h03;
endpackage

/* hdl/lvpc_classifier.sv */
// Single-entry LLC and 802.1P/Q classifier match engine
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (R01) TCP/UDP destination port matches only inside low..high inclusive.
// (R02) Missing low port bound defaults to zero.
// (R03) Port bounds ignored for IP frames carrying neither TCP nor UDP.
// (R04) Destination MAC matches when frame address AND mask equals configured address.
// (R05) Source MAC needs exact match; ignored when not configured.
// (R06) Selector 0 disables protocol criterion and ignores value bytes.
// (R07) Selector 1 matches frames with Ethertype equal to value bytes.
// (R08) Selector 2 matches 802.2 frames, DSAP not 0xAA, equal to low byte.
// (R09) Selector 3 matches management frames with type inside value range.
// (R10) Management types 4, 6, 7, 14 never classified; go to primary flow.
// (R11) Selector 4 matches every data PDU, never management messages.
// (R12) For tagged frames the inner Ethertype is used for protocol matching.
// (R13) Selectors above 4 reserved; absent protocol parameter ignores protocol.
// (R14) Priority matches inside configured low..high, each 0 to 7.
// (R15) Priority or VLAN criterion rejects untagged frames.
// (R16) Cable modem without tag forwarding disables priority or VLAN entries.
// (R17) Only top 12 bits of VLAN parameter compared with frame VLAN.
// (R18) Vendor block discarded when its first TLV is not a vendor ID.
// (R19) Multi-octet values are most significant octet first.
// (R20) LLC parameters under subtype 10, 802.1P/Q under subtype 11.
// (R21) Upstream flow groups are type 24, downstream type 25.
// (R22) Match only when every configured criterion matches.
module lvpc_classifier
    import lvpc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    // Classifier entry parameters, network order
    input  wire logic        i_dport_low_present,
    input  wire logic [15:0] i_dport_low,
    input  wire logic        i_dport_high_present,
    input  wire logic [15:0] i_dport_high,
    input  wire logic        i_dmac_present,
    input  wire logic [95:0] i_dmac_param,
    input  wire logic        i_smac_present,
    input  wire logic [47:0] i_smac_param,
    input  wire logic        i_proto_present,
    input  wire logic [7:0]  i_proto_sel,
    input  wire logic [7:0]  i_proto_value_high_byte,
    input  wire logic [7:0]  i_proto_value_low_byte,
    input  wire logic        i_pri_present,
    input  wire logic [7:0]  i_pri_low,
    input  wire logic [7:0]  i_pri_high,
    input  wire logic        i_vlan_present,
    input  wire logic [15:0] i_vlan_param,
    input  wire logic        i_vendor_present,
    input  wire logic [7:0]  i_vendor_first_type,
    input  wire logic        i_cable_modem_no_tag_fwd,
    // Parsed frame header, one-cycle strobe
    input  wire logic        i_frm_valid,
    input  wire logic [47:0] i_frm_dmac,
    input  wire logic [47:0] i_frm_smac,
    input  wire logic        i_frm_is_mgmt,
    input  wire logic [7:0]  i_frm_fc,
    input  wire logic [7:0]  i_frm_mgmt_type,
    input  wire logic        i_frm_has_etype,
    input  wire logic [15:0] i_frm_etype,
    input  wire logic [15:0] i_frm_inner_etype,
    input  wire logic        i_frm_is_llc,
    input  wire logic [7:0]  i_frm_dsap,
    input  wire logic        i_frm_tagged,
    input  wire logic [2:0]  i_frm_pri,
    input  wire logic [11:0] i_frm_vlan,
    input  wire logic        i_frm_is_ip,
    input  wire logic        i_frm_is_tcp_udp,
    input  wire logic [15:0] i_frm_dport,
    // Decision outputs
    output logic             o_result_valid,
    output logic             o_match,
    output logic             o_force_primary,
    output logic             o_vendor_discard
);

    logic rst_meta;
    logic rst_sync;
    logic [15:0] port_lo;
    logic [15:0] port_hi;
    logic [15:0] proto_val;
    logic [15:0] eff_etype;
    logic        mgmt_fc;
    logic        mgmt_excluded;
    logic        port_ok;
    logic        dmac_ok;
    logic        smac_ok;
    logic        proto_ok;
    logic        pri_ok;
    logic        vlan_ok;
    logic        entry_live;
    logic        next_match;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Management types that bypass classification
    function automatic logic mgmt_never_classified(input logic [7:0] t);
        return (t == MT_RNG_REQ) || (t == MT_REG_REQ) ||
               (t == MT_REG_RSP) || (t == MT_REG_ACK);            // R10
    endfunction

    // Inclusive range check shared by ports, priority and management types
    function automatic logic in_range16(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    // Defaults for missing port bounds
    assign port_lo   = i_dport_low_present  ? i_dport_low  : PORT_LOW_DEF;   // R02
    assign port_hi   = i_dport_high_present ? i_dport_high : PORT_HIGH_DEF;  // R01
    // Value bytes arrive high byte first
    assign proto_val = {i_proto_value_high_byte, i_proto_value_low_byte};   // R19
    // A tag header hides the real Ethertype one level deeper
    assign eff_etype = (i_frm_etype == ETYPE_VLAN) ? i_frm_inner_etype
                                                   : i_frm_etype;       // R12
    assign mgmt_fc       = i_frm_is_mgmt && (i_frm_fc[7:1] == FC_MGMT_HI);
    assign mgmt_excluded = mgmt_fc && mgmt_never_classified(i_frm_mgmt_type); // R10

    // Port criterion only bites for TCP/UDP inside IP
    assign port_ok = !(i_frm_is_ip && i_frm_is_tcp_udp) ||
                     in_range16(i_frm_dport, port_lo, port_hi);          // R01 R03

    // Address first, mask second in the 12-byte parameter
    assign dmac_ok = !i_dmac_present ||
                     ((i_frm_dmac & i_dmac_param[47:0]) == i_dmac_param[95:48]); // R04
    assign smac_ok = !i_smac_present || (i_frm_smac == i_smac_param);   // R05

    // Layer-3 protocol selector decode
    always_comb begin
        proto_ok = 1'b1;                                                 // R13
        if (i_proto_present) begin
            unique case (i_proto_sel)
                SEL_NONE:      proto_ok = 1'b1;                          // R06
                SEL_ETHERTYPE: proto_ok = !i_frm_is_mgmt && i_frm_has_etype &&
                                          (eff_etype == proto_val);      // R07
                SEL_DSAP:      proto_ok = !i_frm_is_mgmt && i_frm_is_llc &&
                                          (i_frm_dsap != DSAP_SNAP) &&
                                          (i_frm_dsap == proto_val[7:0]); // R08
                SEL_MGMT:      proto_ok = mgmt_fc &&
                                          in_range16({8'h00, i_frm_mgmt_type},
                                                     {8'h00, i_proto_value_high_byte},
                                                     {8'h00, i_proto_value_low_byte}); // R09
                SEL_DATA_ALL:  proto_ok = !i_frm_is_mgmt;               // R11
                // Reserved selectors match nothing
                default:       proto_ok = 1'b0;                          // R13
            endcase
        end
    end

    // Priority and VLAN need a tagged frame
    assign pri_ok  = !i_pri_present ||
                     (i_frm_tagged &&
                      in_range16({13'h0000, i_frm_pri}, {8'h00, i_pri_low},
                                 {8'h00, i_pri_high}));                  // R14 R15
    assign vlan_ok = !i_vlan_present ||
                     (i_frm_tagged && (i_frm_vlan == i_vlan_param[15:4])); // R15 R17
    // Modem without tag forwarding kills entries that need tags
    assign entry_live = !(i_cable_modem_no_tag_fwd &&
                          (i_pri_present || i_vlan_present));            // R16

    // Every configured criterion must agree
    assign next_match = entry_live && !mgmt_excluded && port_ok && dmac_ok &&
                        smac_ok && proto_ok && pri_ok && vlan_ok;        // R22

    // Registered decision
    always_ff @(posedge i_clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            o_result_valid  <= 1'b0;
            o_match         <= 1'b0;
            o_force_primary <= 1'b0;
        end else begin
            o_result_valid  <= i_frm_valid;
            o_match         <= i_frm_valid && next_match;
            o_force_primary <= i_frm_valid && mgmt_excluded;             // R10
        end
    end

    // Vendor block whose first TLV is not a vendor ID is dropped
    always_ff @(posedge i_clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            o_vendor_discard <= 1'b0;
        end else begin
            o_vendor_discard <= i_vendor_present &&
                                (i_vendor_first_type != TLV_VENDOR_ID);  // R18
        end
    end

    // Checks
    a_excluded_never_match: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        (i_frm_valid && mgmt_excluded) |=> (!o_match && o_force_primary)) // R10
        else $error("excluded management type matched");
    a_port_range_check: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        (i_frm_valid && i_frm_is_ip && i_frm_is_tcp_udp && (i_frm_dport > port_hi))
        |=> !o_match) // R01
        else $error("port above bound matched");
    a_untagged_reject: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        (i_frm_valid && !i_frm_tagged && (i_pri_present || i_vlan_present))
        |=> !o_match) // R15
        else $error("untagged frame matched tag criterion");
    a_dmac_mismatch: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        (i_frm_valid && i_dmac_present &&
         ((i_frm_dmac & i_dmac_param[47:0]) != i_dmac_param[95:48])) |=> !o_match) // R04
        else $error("masked destination mismatch matched");
    a_smac_mismatch: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        (i_frm_valid && i_smac_present && (i_frm_smac != i_smac_param)) |=> !o_match) // R05
        else $error("source mismatch matched");
    a_catchall_mgmt: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        (i_frm_valid && i_proto_present && (i_proto_sel == SEL_DATA_ALL) && i_frm_is_mgmt)
        |=> !o_match) // R11
        else $error("catch-all matched management");
    a_nontag_modem: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        (i_frm_valid && i_cable_modem_no_tag_fwd && i_vlan_present) |=> !o_match) // R16
        else $error("disabled entry matched");
    a_vendor_discard: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        (i_vendor_present && (i_vendor_first_type != TLV_VENDOR_ID))
        |=> o_vendor_discard) // R18
        else $error("bad vendor block kept");
    a_reserved_sel: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        (i_frm_valid && i_proto_present && (i_proto_sel > SEL_DATA_ALL)) |=> !o_match) // R13
        else $error("reserved selector matched");
    a_dsap_snap: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        (i_frm_valid && i_proto_present && (i_proto_sel == SEL_DSAP) &&
         (i_frm_dsap == DSAP_SNAP)) |=> !o_match) // R08
        else $error("SNAP DSAP matched");
    a_valid_follows: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        i_frm_valid |=> o_result_valid) // R22
        else $error("result strobe missing");

    // Frame steps: a frame taken under a condition, then no match the cycle after
    sequence s_frame_with(cond);
        i_frm_valid && cond;
    endsequence
    sequence s_no_match;
        !o_match;
    endsequence

    a_valid_pulse: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        !i_frm_valid |=> !o_result_valid) // R22
        else $error("result strobe without frame");
    a_match_qualified: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        o_match |-> o_result_valid) // R22
        else $error("match outside result strobe");
    a_primary_exclusive: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        o_force_primary |-> !o_match) // R10
        else $error("primary frame also matched");
    a_port_below_low: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        s_frame_with(i_frm_is_ip && i_frm_is_tcp_udp && (i_frm_dport < port_lo))
        |=> s_no_match) // R02
        else $error("port below bound matched");
    a_pri_outside: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        s_frame_with(i_pri_present && ((i_frm_pri < i_pri_low[2:0]) ||
                     (i_frm_pri > i_pri_high[2:0]) || (i_pri_low[7:3] != 5'h00)
                     || (i_pri_high[7:3] != 5'h00)) && (i_pri_high[7:3] == 5'h00)
                     && (i_pri_low[7:3] == 5'h00))
        |=> s_no_match) // R14
        else $error("priority outside range matched");
    a_vlan_mismatch: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        s_frame_with(i_vlan_present && (i_frm_vlan != i_vlan_param[15:4]))
        |=> s_no_match) // R17
        else $error("vlan mismatch matched");
    a_etype_mismatch: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        s_frame_with(i_proto_present && (i_proto_sel == SEL_ETHERTYPE) &&
                     (eff_etype != proto_val))
        |=> s_no_match) // R07 R12
        else $error("ethertype mismatch matched");
    a_mgmt_outside: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        s_frame_with(i_proto_present && (i_proto_sel == SEL_MGMT) &&
                     ((i_frm_mgmt_type < i_proto_value_high_byte) ||
                      (i_frm_mgmt_type > i_proto_value_low_byte)))
        |=> s_no_match) // R09
        else $error("management type outside range matched");
    a_pri_modem: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
        s_frame_with(i_cable_modem_no_tag_fwd && i_pri_present)
        |=> s_no_match) // R16
        else $error("disabled priority entry matched");

endmodule // lvpc_classifier
`default_nettype wire

/* test/lvpc_fwd_model.sv */
// Forwarding path model that steers classifier decisions to flows
`timescale 1ns/1ps
`default_nettype none
module lvpc_fwd_model (
    // Clock and decision inputs
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic        i_valid,
    input  wire logic        i_match,
    input  wire logic        i_force_primary,
    // Flow counters
    output logic      [15:0] o_n_classified,
    output logic      [15:0] o_n_primary
);
    // Excluded management frames go to the primary flow, matches to this entry
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_n_classified <= 16'h0000;
            o_n_primary    <= 16'h0000;
        end else begin
            if (i_valid && i_force_primary) o_n_primary <= o_n_primary + 16'h0001;
            if (i_valid && i_match) o_n_classified <= o_n_classified + 16'h0001;
        end
    end
endmodule // lvpc_fwd_model
`default_nettype wire

/* test/lvpc_classifier_tb.sv */
// Random self-checking testbench for the classifier match engine
`timescale 1ns/1ps
`default_nettype none
module lvpc_classifier_tb import lvpc_pkg::*;;
    logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_frm_valid = 1'b0;
    logic i_dport_low_present, i_dport_high_present, i_dmac_present, i_smac_present;
    logic i_proto_present, i_pri_present, i_vlan_present, i_vendor_present;
    logic i_cable_modem_no_tag_fwd, i_frm_is_mgmt, i_frm_has_etype, i_frm_is_llc;
    logic i_frm_tagged, i_frm_is_ip, i_frm_is_tcp_udp;
    logic o_result_valid, o_match, o_force_primary, o_vendor_discard;
    logic [95:0] i_dmac_param;
    logic [47:0] i_smac_param, i_frm_dmac, i_frm_smac;
    logic [15:0] i_dport_low, i_dport_high, i_vlan_param, i_frm_etype, i_frm_inner_etype;
    logic [15:0] i_frm_dport, n_cls, n_pri;
    logic [11:0] i_frm_vlan;
    logic [7:0]  i_proto_sel, i_proto_value_high_byte, i_proto_value_low_byte, i_pri_low;
    logic [7:0]  i_pri_high, i_vendor_first_type, i_frm_fc, i_frm_mgmt_type, i_frm_dsap;
    logic [2:0]  i_frm_pri;
    logic        em, ef, ev;
    int          n_mismatch = 0, samples_checked = 0;
    logic [15:0] exp_cls = 16'h0000, exp_pri = 16'h0000;
    integer      seed = 32'h489a_c3bf;

    lvpc_classifier lvpc_classifier_i (.*);
    lvpc_fwd_model lvpc_fwd_model_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_valid(o_result_valid),
        .i_match(o_match), .i_force_primary(o_force_primary),
        .o_n_classified(n_cls), .o_n_primary(n_pri));

    // 200 MHz clock
    always #2.5 i_clk_sys = ~i_clk_sys;

    // Random entry and frame; fields are steered to hit equality and range edges
    task automatic rnd();
        logic [31:0] r, a, b, c;
        r = $random(seed);
        a = $random(seed);
        b = $random(seed);
        c = $random(seed);
        {i_dport_low_present, i_dport_high_present, i_dmac_present, i_smac_present,
         i_proto_present, i_pri_present, i_vlan_present, i_vendor_present,
         i_cable_modem_no_tag_fwd} <= r[8:0] & a[24:16];
        {i_frm_is_mgmt, i_frm_has_etype, i_frm_is_llc, i_frm_tagged, i_frm_is_ip,
         i_frm_is_tcp_udp} <= r[14:9];
        i_dport_low <= a[15:0];
        i_dport_high <= a[15:0] + {8'h00, a[23:16]};
        i_frm_dport <= r[16] ? a[15:0] + {14'h0000, r[18:17]} : c[31:16];
        i_dmac_param <= {c[15:0], b, r[20] ? 48'hFFFF_FFFF_FFFF : {a[15:0], c}};
        i_frm_dmac <= r[19] ? {c[15:0], b} : {a[15:0], c};
        i_smac_param <= {c[31:16], b};
        i_frm_smac <= r[21] ? {c[31:16], b} : {a[31:16], c};
        i_proto_sel <= {5'h00, b[2:0]};
        i_proto_value_high_byte <= {4'h0, b[11:8]};
        i_proto_value_low_byte <= {4'h0, b[15:12]};
        i_frm_etype <= r[22] ? {4'h0, b[11:8], 4'h0, b[15:12]} : (r[23] ? ETYPE_VLAN : c[15:0]);
        i_frm_inner_etype <= r[24] ? {4'h0, b[11:8], 4'h0, b[15:12]} : c[31:16];
        i_frm_dsap <= r[25] ? {4'h0, b[15:12]} : (r[26] ? DSAP_SNAP : c[7:0]);
        i_frm_fc <= r[27] ? {FC_MGMT_HI, b[16]} : c[7:0];
        i_frm_mgmt_type <= {4'h0, b[20:17]};
        i_pri_low <= {5'h00, b[23:21]};
        i_pri_high <= {5'h00, b[26:24]};
        i_frm_pri <= b[29:27];
        i_vlan_param <= c[15:0];
        i_frm_vlan <= r[28] ? c[15:4] : c[27:16];
        i_vendor_first_type <= r[29] ? TLV_VENDOR_ID : c[7:0];
    endtask

    // Management frame of an excluded type
    function automatic logic exp_fp();
        return i_frm_is_mgmt && (i_frm_fc[7:1] == FC_MGMT_HI) && (i_frm_mgmt_type == MT_RNG_REQ ||
            i_frm_mgmt_type == MT_REG_REQ || i_frm_mgmt_type == MT_REG_RSP ||
            i_frm_mgmt_type == MT_REG_ACK);
    endfunction

    // Every configured criterion must hold; absent ones never reject
    function automatic logic exp_match();
        logic        m;
        logic [15:0] lo, hi, et, pv;
        lo = i_dport_low_present ? i_dport_low : 16'h0000;
        hi = i_dport_high_present ? i_dport_high : 16'hFFFF;
        et = (i_frm_etype == ETYPE_VLAN) ? i_frm_inner_etype : i_frm_etype;
        pv = {i_proto_value_high_byte, i_proto_value_low_byte};
        m = !exp_fp();
        if (i_frm_is_ip && i_frm_is_tcp_udp && (i_frm_dport < lo || i_frm_dport > hi)) m = 0;
        if (i_dmac_present && (i_frm_dmac & i_dmac_param[47:0]) != i_dmac_param[95:48]) m = 0;
        if (i_smac_present && i_frm_smac != i_smac_param) m = 0;
        if (i_proto_present) begin
            case (i_proto_sel)
                SEL_NONE: ;
                SEL_ETHERTYPE: if (i_frm_is_mgmt || !i_frm_has_etype || et != pv) m = 0;
                SEL_DSAP: if (i_frm_is_mgmt || !i_frm_is_llc || i_frm_dsap == DSAP_SNAP ||
                    i_frm_dsap != pv[7:0]) m = 0;
                SEL_MGMT: if (!i_frm_is_mgmt || i_frm_fc[7:1] != FC_MGMT_HI ||
                    i_frm_mgmt_type < pv[15:8] || i_frm_mgmt_type > pv[7:0]) m = 0;
                SEL_DATA_ALL: if (i_frm_is_mgmt) m = 0;
                default: m = 0;
            endcase
        end
        if ((i_pri_present || i_vlan_present) &&
            (!i_frm_tagged || i_cable_modem_no_tag_fwd)) m = 0;
        if (i_pri_present &&
            ({5'h00, i_frm_pri} < i_pri_low || {5'h00, i_frm_pri} > i_pri_high)) m = 0;
        if (i_vlan_present && i_frm_vlan != i_vlan_param[15:4]) m = 0;
        return m;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        samples_checked++;
        if (got !== want) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence: one frame every two cycles, checked the cycle after it is taken
    initial begin
        rnd();
        repeat (12) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        for (int k = 0; k < 2000; k++) begin
            @(posedge i_clk_sys);
            rnd();
            i_frm_valid <= 1'b1;
            @(posedge i_clk_sys);
            i_frm_valid <= 1'b0;
            em = exp_match();
            ef = exp_fp();
            ev = i_vendor_present && (i_vendor_first_type != TLV_VENDOR_ID);
            exp_cls = exp_cls + {15'h0000, em};
            exp_pri = exp_pri + {15'h0000, ef};
            #1;
            chk({15'h0000, o_result_valid}, 16'h0001);
            chk({15'h0000, o_match}, {15'h0000, em});
            chk({15'h0000, o_force_primary}, {15'h0000, ef});
            chk({15'h0000, o_vendor_discard}, {15'h0000, ev});
        end
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk(n_cls, exp_cls);
        chk(n_pri, exp_pri);
        end_of_test();
    end

    // Watchdog sized well beyond the 4000-cycle frame run
    initial begin
        repeat (10000) @(posedge i_clk_sys);
        n_mismatch++;
        end_of_test();
    end
endmodule // lvpc_classifier_tb
`default_nettype wire
